// ===== src/ebt_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the timer.
// Assumes: Register port carries an 8-bit data word and a 3-bit address.
// Notes:   Definitions only.
`ifndef EBT_MAP_SVH
`define EBT_MAP_SVH

// Register addresses on the plain register port.
`define EBT_ADDR_CONTROL   3'h0
`define EBT_ADDR_COUNT     3'h1
`define EBT_ADDR_CMP_A     3'h2
`define EBT_ADDR_CMP_B     3'h3
`define EBT_ADDR_MASK      3'h4
`define EBT_ADDR_FLAGS     3'h5

// Control register fields.
`define EBT_CTRL_CTC_BIT   3
`define EBT_CTRL_CS_LSB    0
`define EBT_CTRL_CS_MSB    2

// Flag and mask bit positions.
`define EBT_BIT_WRAP       0
`define EBT_BIT_MATCH_A    1
`define EBT_BIT_MATCH_B    2

// Counter limits and reset values.
`define EBT_MAX            8'hFF
`define EBT_ZERO           8'h00
`define EBT_RESET_BYTE     8'h00
`define EBT_RESET_CS       3'h0

// Prescaler divide ratios, expressed as terminal counts of a 10-bit counter.
`define EBT_DIV8_MASK      10'h007
`define EBT_DIV64_MASK     10'h03F
`define EBT_DIV256_MASK    10'h0FF
`define EBT_DIV1024_MASK   10'h3FF

`endif

// ===== src/ebt_pkg.sv
// Purpose: Types shared by the eight-bit timer.
// Assumes: Constants live in ebt_map.svh.
// Notes:   Clock-source codes are the field encoding written to control.
package ebt_pkg;

    typedef enum logic [2:0] {
        EBT_CS_STOP   = 3'b000,
        EBT_CS_DIV1   = 3'b001,
        EBT_CS_DIV8   = 3'b010,
        EBT_CS_DIV64  = 3'b011,
        EBT_CS_DIV256 = 3'b100,
        EBT_CS_DIV1K  = 3'b101,
        EBT_CS_EXT_FA = 3'b110,
        EBT_CS_EXT_RI = 3'b111
    } ebt_cs_t;

    // Register port request from the processor.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ebt_req_t;

    // Interrupt requests and acknowledges, one bit per source.
    typedef struct packed {
        logic match_b;
        logic match_a;
        logic wrap;
    } ebt_irq_t;

endpackage : ebt_pkg

// ===== src/ebt_timer.sv
// Purpose: Eight-bit up-counting timer with two compare units and three flags.
// Assumes: All inputs synchronous to clk; the count pin is already synchronised.
// Notes:   Notes on behaviour and tags below.
//
// Notes on behaviour
// - Count maximum is 0xFF in every mode.
// - Top is 0xFF or compare A by mode.
// - Count and compares are 8-bit read/write.
// - Each request has flag and mask bit.
// - Clock source zero stops the counter entirely.
// - Clock select makes one tick enable.
// - Count is accessible whether or not ticking.
// - Count write beats clear and increment.
// - Tick increments or clears; otherwise holds.
// - Equality sets match flag at next tick.
// - Match flags clear on service or write-one.
// - Set and unmasked match flag raises request.
// - Count write blocks matches on next tick.
// - Normal mode counts up, wraps 0xFF to 0x00.
// - Wrap flag set as count wraps, sticky.
// - Clear-on-match mode clears at compare A.
// - Compare A unbuffered; missed match runs to 0xFF.
// - Clear-on-match mode also flags wrap at maximum.
// - Clock-source codes: stop, 1, 8, 64, 256, 1024, pin.
// - Pin edges count even when pin is output.
// - Wrap flag clears on service or write-one.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ebt_map.svh"

module ebt_timer (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // Power gate; high holds the timer disabled.
    input  wire logic              power_gate,
    // Register port.
    input  wire ebt_pkg::ebt_req_t req,
    output logic [7:0]             rdata,
    // External count pin level, sampled directly.
    input  wire logic              external_count_pin,
    // Interrupt requests and acknowledges from the interrupt controller.
    output ebt_pkg::ebt_irq_t      irq,
    input  wire ebt_pkg::ebt_irq_t irq_ack
);
    import ebt_pkg::*;

    logic [7:0] count_value_q;
    logic [7:0] compare_a_value_q;
    logic [7:0] compare_b_value_q;
    logic       clear_on_match_select_q;
    ebt_cs_t    clock_source_field_q;
    logic [2:0] timer_mask_register_q;
    logic [2:0] timer_flag_register_q;
    logic [9:0] prescale_q;
    logic       pin_q;
    logic       block_q;
    logic [7:0] rdata_q;
    logic       timer_tick;
    logic       count_wr;
    logic       match_a;
    logic       match_b;
    logic       at_top;
    logic       wrap_ev;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;

    // Prescaler terminal-count test, used for each divided source.
    function automatic logic div_hit(input logic [9:0] cnt, input logic [9:0] mask);
        div_hit = ((cnt & mask) == mask);
    endfunction : div_hit

    // Free-running prescaler; held at zero while the module is power-gated.
    always_ff @(posedge clk) begin
        if (rst || power_gate) begin
            prescale_q <= 10'h000;
        end else begin
            prescale_q <= prescale_q + 10'h001;
        end
    end

    // Previous pin level for edge detection; pin is read regardless of direction.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= external_count_pin;
        end
    end

    // Clock select produces the single tick enable.
    always_comb begin
        timer_tick = 1'b0;
        case (clock_source_field_q)
            EBT_CS_STOP:   timer_tick = 1'b0;
            EBT_CS_DIV1:   timer_tick = 1'b1;
            EBT_CS_DIV8:   timer_tick = div_hit(prescale_q, `EBT_DIV8_MASK);
            EBT_CS_DIV64:  timer_tick = div_hit(prescale_q, `EBT_DIV64_MASK);
            EBT_CS_DIV256: timer_tick = div_hit(prescale_q, `EBT_DIV256_MASK);
            EBT_CS_DIV1K:  timer_tick = div_hit(prescale_q, `EBT_DIV1024_MASK);
            EBT_CS_EXT_FA: timer_tick = pin_q && !external_count_pin;
            EBT_CS_EXT_RI: timer_tick = !pin_q && external_count_pin;
            default:       timer_tick = 1'b0;
        endcase
        if (power_gate) begin
            timer_tick = 1'b0;
        end
    end

    // Compare and top detection; comparators run every cycle.
    assign count_wr = req.wr && (req.addr == `EBT_ADDR_COUNT) && !power_gate;
    assign match_a  = (count_value_q == compare_a_value_q);
    assign match_b  = (count_value_q == compare_b_value_q);
    // Top is compare A only in clear-on-match mode, else the fixed maximum.
    assign at_top   = clear_on_match_select_q ? match_a : (count_value_q == `EBT_MAX);
    // Wrap happens when the count leaves maximum on a tick in either mode.
    assign wrap_ev  = timer_tick && !count_wr && (count_value_q == `EBT_MAX);

    // Counter: a processor write wins; otherwise clear at top or increment on a tick.
    always_ff @(posedge clk) begin
        if (rst) begin
            count_value_q <= `EBT_RESET_BYTE;
        end else if (count_wr) begin
            count_value_q <= req.wdata;
        end else if (timer_tick) begin
            if (clear_on_match_select_q && match_a) begin
                count_value_q <= `EBT_ZERO;
            end else begin
                // Past compare A the count runs through 0xFF and wraps.
                count_value_q <= count_value_q + 8'h01;
            end
        end
    end

    // A count write blocks matches on the next tick, even while stopped.
    always_ff @(posedge clk) begin
        if (rst) begin
            block_q <= 1'b0;
        end else if (count_wr) begin
            block_q <= 1'b1;
        end else if (timer_tick) begin
            block_q <= 1'b0;
        end
    end

    // Configuration registers, written by the processor.
    always_ff @(posedge clk) begin
        if (rst) begin
            compare_a_value_q       <= `EBT_RESET_BYTE;
            compare_b_value_q       <= `EBT_RESET_BYTE;
            clear_on_match_select_q <= 1'b0;
            clock_source_field_q    <= EBT_CS_STOP;
            timer_mask_register_q   <= 3'h0;
        end else if (req.wr && !power_gate) begin
            if (req.addr == `EBT_ADDR_CONTROL) begin
                clear_on_match_select_q <= req.wdata[`EBT_CTRL_CTC_BIT];
                clock_source_field_q    <= ebt_cs_t'(req.wdata[`EBT_CTRL_CS_MSB:`EBT_CTRL_CS_LSB]);
            end else if (req.addr == `EBT_ADDR_CMP_A) begin
                compare_a_value_q <= req.wdata;
            end else if (req.addr == `EBT_ADDR_CMP_B) begin
                compare_b_value_q <= req.wdata;
            end else if (req.addr == `EBT_ADDR_MASK) begin
                timer_mask_register_q <= req.wdata[2:0];
            end
        end
    end

    // Flag events and clears; a set in the same cycle as a clear wins.
    always_comb begin
        flag_set                   = 3'h0;
        flag_set[`EBT_BIT_WRAP]    = wrap_ev;
        flag_set[`EBT_BIT_MATCH_A] = timer_tick && match_a && !block_q;
        flag_set[`EBT_BIT_MATCH_B] = timer_tick && match_b && !block_q;
        flag_clr = irq_ack;
        if (req.wr && (req.addr == `EBT_ADDR_FLAGS) && !power_gate) begin
            flag_clr = flag_clr | req.wdata[2:0];
        end
    end

    // Sticky flags.
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_flag_register_q <= 3'h0;
        end else begin
            timer_flag_register_q <= flag_set | (timer_flag_register_q & ~flag_clr);
        end
    end

    // Requests are flag and mask together.
    assign irq = ebt_irq_t'(timer_flag_register_q & timer_mask_register_q);

    // Read data registered one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            if (req.addr == `EBT_ADDR_CONTROL) begin
                rdata_q <= {4'h0, clear_on_match_select_q, clock_source_field_q};
            end else if (req.addr == `EBT_ADDR_COUNT) begin
                rdata_q <= count_value_q;
            end else if (req.addr == `EBT_ADDR_CMP_A) begin
                rdata_q <= compare_a_value_q;
            end else if (req.addr == `EBT_ADDR_CMP_B) begin
                rdata_q <= compare_b_value_q;
            end else if (req.addr == `EBT_ADDR_MASK) begin
                rdata_q <= {5'h00, timer_mask_register_q};
            end else if (req.addr == `EBT_ADDR_FLAGS) begin
                rdata_q <= {5'h00, timer_flag_register_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;

    // Checks.
    property p_write_wins;
        @(posedge clk) disable iff (rst)
        count_wr |=> (count_value_q == $past(req.wdata));
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("count write lost");

    property p_stop_holds;
        @(posedge clk) disable iff (rst)
        (clock_source_field_q == EBT_CS_STOP && !count_wr) |=> $stable(count_value_q);
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

    property p_wrap;
        @(posedge clk) disable iff (rst)
        (timer_tick && !count_wr && count_value_q == 8'hFF)
            |=> (count_value_q == 8'h00) && timer_flag_register_q[0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap not flagged");

    property p_ctc_clear;
        @(posedge clk) disable iff (rst)
        (timer_tick && !count_wr && clear_on_match_select_q && match_a) |=> count_value_q == 8'h00;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("no clear at compare A");

    property p_increment;
        @(posedge clk) disable iff (rst)
        (timer_tick && !count_wr && !at_top) |=> count_value_q == $past(count_value_q) + 8'h01;
    endproperty
    a_increment: assert property (p_increment) else $error("tick did not increment");

    sequence s_wr_then_tick;
        count_wr ##1 (!count_wr)[*1] ##0 timer_tick;
    endsequence
    property p_block;
        @(posedge clk) disable iff (rst)
        (s_wr_then_tick and ##1 !timer_flag_register_q[1] && !irq_ack[1])
            |=> !timer_flag_register_q[1];
    endproperty
    a_block: assert property (p_block) else $error("match not blocked after write");

    property p_match_b;
        @(posedge clk) disable iff (rst)
        (timer_tick && match_b && !block_q) |=> timer_flag_register_q[2];
    endproperty
    a_match_b: assert property (p_match_b) else $error("match B not flagged");

    property p_irq;
        @(posedge clk) disable iff (rst)
        (timer_flag_register_q[1] && timer_mask_register_q[1]) |-> irq.match_a;
    endproperty
    a_irq: assert property (p_irq) else $error("request missing");

    property p_clear_one;
        @(posedge clk) disable iff (rst)
        (req.wr && req.addr == 3'h5 && req.wdata[0] && !power_gate && !wrap_ev)
            |=> !timer_flag_register_q[0];
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("write one did not clear");

    // Reset clears count, compare A, control, mask and flags.
    property p_reset_zero;
        @(posedge clk)
        rst |=> (count_value_q == `EBT_RESET_BYTE) && (compare_a_value_q == `EBT_RESET_BYTE)
            && (timer_flag_register_q == 3'h0) && (timer_mask_register_q == 3'h0)
            && !clear_on_match_select_q && (clock_source_field_q == EBT_CS_STOP);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("state not cleared by reset");

    // While gated the timer neither counts nor takes configuration writes.
    property p_gate_holds;
        @(posedge clk) disable iff (rst)
        power_gate |=> $stable(count_value_q) && $stable(compare_a_value_q)
            && $stable(timer_mask_register_q);
    endproperty
    a_gate_holds: assert property (p_gate_holds) else $error("gated timer changed");

    property p_tick_hold;
        @(posedge clk) disable iff (rst)
        (!timer_tick && !count_wr) |=> $stable(count_value_q);
    endproperty
    a_tick_hold: assert property (p_tick_hold) else $error("count moved between ticks");

    property p_normal_up;
        @(posedge clk) disable iff (rst)
        (!clear_on_match_select_q && timer_tick && !count_wr)
            |=> count_value_q == $past(count_value_q) + 8'h01;
    endproperty
    a_normal_up: assert property (p_normal_up) else $error("normal mode did not count up");

    property p_match_a;
        @(posedge clk) disable iff (rst)
        (timer_tick && match_a && !block_q) |=> timer_flag_register_q[`EBT_BIT_MATCH_A];
    endproperty
    a_match_a: assert property (p_match_a) else $error("match A not flagged");

    // The wrap flag only rises on a tick that leaves the maximum.
    property p_wrap_only;
        @(posedge clk) disable iff (rst)
        (!timer_flag_register_q[`EBT_BIT_WRAP]
            && !(timer_tick && !count_wr && count_value_q == `EBT_MAX))
            |=> !timer_flag_register_q[`EBT_BIT_WRAP];
    endproperty
    a_wrap_only: assert property (p_wrap_only) else $error("wrap flag set without wrap");

    // Service of match B clears its flag unless a new match lands at once.
    property p_ack_clear;
        @(posedge clk) disable iff (rst)
        (irq_ack.match_b && !(timer_tick && match_b && !block_q))
            |=> !timer_flag_register_q[`EBT_BIT_MATCH_B];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("service did not clear match B");

    // A flag write with a zero in the match A position keeps that flag.
    property p_zero_keeps;
        @(posedge clk) disable iff (rst)
        (timer_flag_register_q[`EBT_BIT_MATCH_A] && !irq_ack.match_a
            && !(req.wr && req.addr == `EBT_ADDR_FLAGS && req.wdata[`EBT_BIT_MATCH_A]))
            |=> timer_flag_register_q[`EBT_BIT_MATCH_A];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("match A flag lost");

    // An armed tick after a count write sets no match B.
    sequence s_armed_tick;
        block_q && timer_tick && !timer_flag_register_q[`EBT_BIT_MATCH_B];
    endsequence
    property p_block_b;
        @(posedge clk) disable iff (rst)
        s_armed_tick |=> !timer_flag_register_q[`EBT_BIT_MATCH_B];
    endproperty
    a_block_b: assert property (p_block_b) else $error("match B not blocked");

    // A pin edge of the selected polarity makes a tick, whatever the pin direction.
    sequence s_pin_edge;
        !power_gate && ((clock_source_field_q == EBT_CS_EXT_RI && $rose(external_count_pin))
            || (clock_source_field_q == EBT_CS_EXT_FA && $fell(external_count_pin)));
    endsequence
    property p_pin_tick;
        @(posedge clk) disable iff (rst)
        s_pin_edge |-> timer_tick;
    endproperty
    a_pin_tick: assert property (p_pin_tick) else $error("pin edge gave no tick");

    // Divide by eight ticks once in every eight cycles of the prescaler.
    property p_div8;
        @(posedge clk) disable iff (rst)
        (clock_source_field_q == EBT_CS_DIV8 && !power_gate)
            |-> (timer_tick == (prescale_q[2:0] == 3'h7));
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight tick misplaced");

    property p_cmp_a_write;
        @(posedge clk) disable iff (rst)
        (req.wr && req.addr == `EBT_ADDR_CMP_A && !power_gate)
            |=> compare_a_value_q == $past(req.wdata);
    endproperty
    a_cmp_a_write: assert property (p_cmp_a_write) else $error("compare A write lost");

    // Read data follow the strobe by one cycle.
    property p_read_count;
        @(posedge clk) disable iff (rst)
        (req.rd && req.addr == `EBT_ADDR_COUNT) |=> rdata == $past(count_value_q);
    endproperty
    a_read_count: assert property (p_read_count) else $error("count read wrong");

endmodule : ebt_timer

// ===== tb/ebt_timer_test.sv
// Purpose: Self-checking bench for the eight-bit timer with two compare units.
// Assumes: Register map and bit layout of ebt_map.svh; mask all ones after setup, except while t_wrap writes 0x06 for its masked check.
// Notes:   Tick counts are fixed by bracketing each run between two control writes, or between power-gate pulses for the prescaled sources.
`timescale 1ns/1ps
`include "ebt_map.svh"

module ebt_timer_test;
    import ebt_pkg::*;

    localparam logic [2:0] A_CTL = `EBT_ADDR_CONTROL;
    localparam logic [2:0] A_CNT = `EBT_ADDR_COUNT;
    localparam logic [2:0] A_CA  = `EBT_ADDR_CMP_A;
    localparam logic [2:0] A_CB  = `EBT_ADDR_CMP_B;
    localparam logic [2:0] A_MSK = `EBT_ADDR_MASK;
    localparam logic [2:0] A_FLG = `EBT_ADDR_FLAGS;

    logic       clk                = 1'b0;
    logic       rst                = 1'b1;
    logic       power_gate         = 1'b0;
    ebt_req_t   req                = '0;
    logic [7:0] rdata;
    logic       external_count_pin = 1'b0;
    ebt_irq_t   irq;
    ebt_irq_t   irq_ack            = '0;
    int         fail_count         = 0;
    int         n_tests            = 0;
    int         cycles             = 0;
    int         divs [4]           = '{8, 64, 256, 1024};

    // Free-running 125 MHz clock.
    always #4 clk = ~clk;

    ebt_timer i_dut (.clk(clk), .rst(rst), .power_gate(power_gate), .req(req), .rdata(rdata),
        .external_count_pin(external_count_pin), .irq(irq), .irq_ack(irq_ack));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // The whole run needs about 3800 cycles, so this ceiling only catches a hang.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            req <= '0;
        end
    endtask : idle

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 check(name, rdata, exp);
    endtask : rd

    task automatic ack(input ebt_irq_t v);
        @(posedge clk);
        irq_ack <= v;
        @(posedge clk);
        irq_ack <= '0;
    endtask : ack

    // Exactly n ticks at source one: the stop write lands n edges after the start write.
    task automatic run(input int n, input logic ctc);
        wr(A_CTL, {4'h0, ctc, 3'h1});
        idle(n - 1);
        wr(A_CTL, {4'h0, ctc, 3'h0});
        idle(1);
    endtask : run

    task automatic t_regs();
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00, "reset value");
        check("irq reset", {5'h0, irq}, 8'h00);
        wr(A_CA, 8'hA5);
        wr(A_CB, 8'h5A);
        wr(A_CNT, 8'h3C);
        wr(A_MSK, 8'hFF);
        wr(A_CTL, 8'hF8);
        wr(3'h6, 8'hFF);
        idle(5);
        rd(A_CA, 8'hA5, "compare a");
        rd(A_CB, 8'h5A, "compare b");
        rd(A_CNT, 8'h3C, "count stopped");
        rd(A_MSK, 8'h07, "mask");
        rd(A_CTL, 8'h08, "control");
        rd(3'h6, 8'h00, "unmapped");
    endtask : t_regs

    task automatic t_wrap();
        wr(A_CA, 8'h90);
        wr(A_CB, 8'h80);
        wr(A_CNT, 8'hFE);
        run(3, 1'b0);
        rd(A_CNT, 8'h01, "wrap count");
        rd(A_FLG, 8'h01, "wrap flag");
        check("irq wrap", {5'h0, irq}, 8'h01);
        wr(A_MSK, 8'h06);
        idle(1);
        #1 check("irq masked", {5'h0, irq}, 8'h00);
        wr(A_MSK, 8'h07);
        wr(A_FLG, 8'h00);
        rd(A_FLG, 8'h01, "write zero keeps");
        ack(3'b001);
        rd(A_FLG, 8'h00, "wrap serviced");
    endtask : t_wrap

    task automatic t_match();
        wr(A_CNT, 8'h7E);
        run(2, 1'b0);
        rd(A_FLG, 8'h00, "match before tick");
        run(1, 1'b0);
        rd(A_FLG, 8'h04, "match b");
        check("irq match", {5'h0, irq}, 8'h04);
        ack(3'b100);
        rd(A_FLG, 8'h00, "match serviced");
        // Written while stopped, equal to compare b: the next tick must not flag.
        wr(A_CNT, 8'h80);
        idle(3);
        run(1, 1'b0);
        rd(A_CNT, 8'h81, "count after block");
        rd(A_FLG, 8'h00, "match blocked");
        wr(A_CTL, 8'h01);
        wr(A_CNT, 8'h40);
        wr(A_CTL, 8'h00);
        rd(A_CNT, 8'h41, "write beats tick");
    endtask : t_match

    task automatic t_ctc();
        wr(A_CA, 8'h03);
        wr(A_CNT, 8'h00);
        run(4, 1'b1);
        rd(A_CNT, 8'h00, "ctc clear");
        rd(A_FLG, 8'h02, "ctc match a");
        check("irq match a", {5'h0, irq}, 8'h02);
        wr(A_FLG, 8'h02);
        rd(A_FLG, 8'h00, "match a write one");
        // Top written below the count: the counter runs on through 0xFF to 0x00.
        wr(A_CA, 8'h10);
        wr(A_CB, 8'h10);
        wr(A_CNT, 8'h20);
        run(224, 1'b1);
        rd(A_CNT, 8'h00, "missed top count");
        rd(A_FLG, 8'h01, "ctc wrap");
        wr(A_FLG, 8'h07);
        rd(A_FLG, 8'h00, "wrap write one");
    endtask : t_ctc

    task automatic t_src();
        for (int i = 0; i < 4; i++) begin
            wr(A_CNT, 8'h00);
            wr(A_CTL, {5'h0, 3'(i + 2)});
            idle(1);
            power_gate <= 1'b1;
            wr(A_CNT, 8'h55);
            idle(1);
            power_gate <= 1'b0;
            // Two and a half periods leave slack of half a period on either side.
            repeat (divs[i] * 5 / 2) @(posedge clk);
            power_gate <= 1'b1;
            rd(A_CNT, 8'h02, "prescaled ticks");
            idle(1);
            power_gate <= 1'b0;
            wr(A_CTL, 8'h00);
        end
        for (int c = 6; c < 8; c++) begin
            wr(A_CNT, 8'h00);
            wr(A_CTL, c[7:0]);
            idle(2);
            repeat (3) begin
                external_count_pin <= 1'b1;
                idle(3);
                external_count_pin <= 1'b0;
                idle(3);
            end
            wr(A_CTL, 8'h00);
            rd(A_CNT, 8'h03, "pin edges");
        end
    endtask : t_src

    // Reset again mid-run, with state left set up by the earlier scenarios.
    task automatic t_reset();
        idle(1);
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00, "reset again");
        check("irq after reset", {5'h0, irq}, 8'h00);
    endtask : t_reset

    // Reset for three cycles, then the scenarios in turn.
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_wrap();
        t_match();
        t_ctc();
        t_src();
        t_reset();
        summarize();
    end

endmodule : ebt_timer_test
